// ===== io_exp_pkg.sv
// shared constants, register map and state record for the motion task i/o expansion
package io_exp_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00; // sequence-step signalling form
  localparam logic [7:0] OFS_IN_MAP = 8'h04; // input function to pin map
  localparam logic [7:0] OFS_OUT_MAP = 8'h08; // output pin to function map
  localparam logic [7:0] OFS_WIN_CFG = 8'h0c; // window flag conditions
  localparam logic [7:0] OFS_STATUS = 8'h10; // read-only status
  // reset values (the default pin functions)
  localparam logic [31:0] RST_CTRL = 32'h0000_0000; // toggle form
  localparam logic [23:0] RST_IN_MAP = 24'hdc_ba98; // pins 8..13
  localparam logic [31:0] RST_OUT_MAP = 32'h9876_5321;
  localparam logic [23:0] RST_WIN_CFG = 24'h00_0980; // flag1=limit1, flag2=limit2
  // field positions
  localparam int CTRL_FORM_BIT = 0; // 0 toggle, 1 level until in position
  localparam int ST_FE_WARN_BIT = 0;
  localparam int ST_RM_WARN_BIT = 1;
  localparam int ST_SEQ_BIT = 2;
  localparam int ST_JOG_BIT = 3;
  localparam int ST_BLK_LSB = 8;
  localparam int ST_PINS_LSB = 16;
  localparam int WIN_EN_BIT = 3; // per 4-bit window field: enable, then 3-bit select
  // input function slots within the input map
  localparam int FN_HOME = 0;
  localparam int FN_CLEAR = 1;
  localparam int FN_NEXT = 2;
  localparam int FN_JOG = 3;
  localparam int FN_RESUME = 4;
  localparam int FN_START = 5;
  // output function codes
  localparam logic [3:0] OF_OFF = 4'h0;
  localparam logic [3:0] OF_TGT = 4'h1;
  localparam logic [3:0] OF_SEQ = 4'h2;
  localparam logic [3:0] OF_FE_N = 4'h3;
  localparam logic [3:0] OF_WIN0 = 4'h4; // window flags 0..5 follow on
  // sizes
  localparam int N_IN = 14;
  localparam int N_OUT = 8;
  localparam int N_FN = 6;
  localparam int CNT_W = 12;
  // input filter timing
  localparam int FILT_TIME_NS = 50000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int FILT_CYCLES_DEF = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // pulses and levels handed to the motion core
  typedef struct packed {
    logic start_task;
    logic [7:0] task_num;
    logic start_home;
    logic start_next;
    logic resume;
    logic jog_start;
    logic jog_cancel;
    logic home_sw;
  } cmd_t;

  // whole state of the block
  typedef struct packed {
    logic [N_IN-1:0] sync1;
    logic [N_IN-1:0] sync2;
    logic [N_IN-1:0] filt;
    logic [N_IN-1:0][CNT_W-1:0] cnt;
    logic [N_FN-1:0] fn_prev;
    logic [31:0] ctrl;
    logic [23:0] in_map;
    logic [31:0] out_map;
    logic [23:0] win_cfg;
    logic [1:0] warn;
    logic seq_lvl;
    logic jog_act;
    logic [5:0] win;
    logic [N_OUT-1:0] outs;
    logic [31:0] prdata;
    cmd_t cmd;
  } state_t;
endpackage

// ===== motion_task_io_expansion.sv
// digital i/o expansion: filtered command inputs, remappable status outputs, apb registers
//
// Design decisions made here: the placing of the registers and register access over APB.
module motion_task_io_expansion #(
  parameter int unsigned FILT_CYCLES = io_exp_pkg::FILT_CYCLES_DEF
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // expansion pins
  input wire logic [io_exp_pkg::N_IN-1:0] i_pins,
  output logic [io_exp_pkg::N_OUT-1:0] o_pins,
  // motion core side
  input wire logic i_pos_in_window,
  input wire logic i_follow_err_exceeded,
  input wire logic [7:0] i_pos_cond,
  input wire logic i_seq_task_start,
  input wire logic i_seq_first,
  input wire logic i_fe_warn_evt,
  input wire logic i_rm_warn_evt,
  input wire logic i_base_home_sel,
  input wire logic i_base_home,
  input wire logic i_base_next_start,
  output io_exp_pkg::cmd_t o_cmd,
  output logic [1:0] o_warn
);
  import io_exp_pkg::*;

  state_t s_r; // registered state
  state_t s_nxt; // next state

  // pick one pin level by 4-bit index, out of range reads low
  function automatic logic pin_of(input logic [N_IN-1:0] v, input logic [3:0] idx);
    pin_of = (int'(idx) < N_IN) ? v[idx] : 1'b0;
  endfunction

  // source level for an output function code
  function automatic logic out_src(input logic [3:0] code, input logic tgt,
                                   input logic seq, input logic fe_n,
                                   input logic [5:0] win);
    if (code == OF_TGT) begin
      out_src = tgt;
    end else if (code == OF_SEQ) begin
      out_src = seq;
    end else if (code == OF_FE_N) begin
      out_src = fe_n;
    end else if (code >= OF_WIN0 && code < OF_WIN0 + 4'd6) begin
      out_src = win[3'(code - OF_WIN0)];
    end else begin
      out_src = 1'b0;
    end
  endfunction

  logic [N_FN-1:0] fn_now; // mapped, filtered command levels
  logic [N_FN-1:0] fn_rise; // rising edges of those
  logic [N_FN-1:0] fn_fall; // falling edges
  logic [7:0] blk_num; // block number from the select pins
  logic setup_ph; // apb setup cycle
  logic access_ph; // apb access cycle
  logic addr_ok; // address decodes to a register
  logic next_req; // next-task request from either source
  // the filter adds latency of about FILT_CYCLES edges to every command taken from the expansion pins;
  // that is the price of rejecting contact bounce

  // address decode and combinational handshake, always zero wait states
  always_comb begin
    setup_ph = i_psel && !i_penable;
    access_ph = i_psel && i_penable;
    addr_ok = (i_paddr == OFS_CTRL) || (i_paddr == OFS_IN_MAP) || (i_paddr == OFS_OUT_MAP)
              || (i_paddr == OFS_WIN_CFG) || (i_paddr == OFS_STATUS);
    o_pready = access_ph;
    o_pslverr = access_ph && !addr_ok;
  end

  // command function levels: each function reads the pin its map names
  always_comb begin
    for (int f = 0; f < N_FN; f++) begin
      fn_now[f] = pin_of(s_r.filt, s_r.in_map[f*4 +: 4]);
    end
    fn_rise = fn_now & ~s_r.fn_prev;
    fn_fall = ~fn_now & s_r.fn_prev;
    blk_num = s_r.filt[7:0];
    next_req = fn_rise[FN_NEXT] || i_base_next_start;
  end

  // next state
  always_comb begin
    s_nxt = s_r;
    // pulses last one cycle
    s_nxt.cmd.start_task = 1'b0;
    s_nxt.cmd.start_home = 1'b0;
    s_nxt.cmd.start_next = 1'b0;
    s_nxt.cmd.resume = 1'b0;
    s_nxt.cmd.jog_start = 1'b0;
    s_nxt.cmd.jog_cancel = 1'b0;

    // two-flop synchroniser, the first stage only feeds the second
    s_nxt.sync1 = i_pins;
    s_nxt.sync2 = s_r.sync1;
    // debounce: a new level must stand for the whole filter time
    for (int k = 0; k < N_IN; k++) begin
      if (s_r.sync2[k] == s_r.filt[k]) begin
        s_nxt.cnt[k] = '0;
      end else if (s_r.cnt[k] == CNT_W'(FILT_CYCLES - 1)) begin
        s_nxt.filt[k] = s_r.sync2[k];
        s_nxt.cnt[k] = '0;
      end else begin
        s_nxt.cnt[k] = s_r.cnt[k] + 1'b1;
      end
    end
    s_nxt.fn_prev = fn_now;

    // home switch: the base unit input wins when configured
    // the expansion pin is still filtered so a later switch-over is clean
    s_nxt.cmd.home_sw = i_base_home_sel ? i_base_home : fn_now[FN_HOME];

    // start addressed task, or homing when block zero is addressed
    if (fn_rise[FN_START]) begin
      if (blk_num != 8'h00) begin
        s_nxt.cmd.start_task = 1'b1;
        s_nxt.cmd.task_num = blk_num;
      end else begin
        s_nxt.cmd.start_home = 1'b1;
      end
    end
    // next task, early requests are dropped rather than stored
    if (next_req && i_pos_in_window) begin
      s_nxt.cmd.start_next = 1'b1;
    end
    // resume is a plain pulse, the core keeps the interrupted task
    if (fn_rise[FN_RESUME]) begin
      s_nxt.cmd.resume = 1'b1;
    end
    // jog follows the pin edges
    if (fn_rise[FN_JOG]) begin
      s_nxt.cmd.jog_start = 1'b1;
      s_nxt.jog_act = 1'b1;
    end else if (fn_fall[FN_JOG] && s_r.jog_act) begin
      s_nxt.cmd.jog_cancel = 1'b1;
      s_nxt.jog_act = 1'b0;
    end

    // warnings: clear first, a same-cycle event then sets again
    if (fn_rise[FN_CLEAR]) begin
      s_nxt.warn = 2'b00;
    end
    if (i_fe_warn_evt) begin
      s_nxt.warn[ST_FE_WARN_BIT] = 1'b1;
    end
    if (i_rm_warn_evt) begin
      s_nxt.warn[ST_RM_WARN_BIT] = 1'b1;
    end

    // sequence-step output
    if (!s_r.ctrl[CTRL_FORM_BIT]) begin
      if (i_seq_task_start && i_seq_first) begin
        s_nxt.seq_lvl = 1'b0;
      end else if (i_seq_task_start) begin
        s_nxt.seq_lvl = !s_r.seq_lvl;
      end
    end else begin
      // alternative form: high from task start until in position
      if (i_seq_task_start) begin
        s_nxt.seq_lvl = 1'b1;
      end else if (i_pos_in_window) begin
        s_nxt.seq_lvl = 1'b0;
      end
    end

    // window flags: each enabled flag follows its selected condition
    // registered once here and again at the pins, hence two edges of lag
    for (int w = 0; w < 6; w++) begin
      s_nxt.win[w] = s_r.win_cfg[w*4 + WIN_EN_BIT] && i_pos_cond[s_r.win_cfg[w*4 +: 3]];
    end

    // output pins through the output map; no wire-break sensing exists
    for (int p = 0; p < N_OUT; p++) begin
      s_nxt.outs[p] = out_src(s_r.out_map[p*4 +: 4], i_pos_in_window, s_r.seq_lvl,
                              !i_follow_err_exceeded, s_r.win);
    end

    // apb read data is fetched in the setup cycle
    // so it stands from a flop by the access edge with no wait state
    if (setup_ph && !i_pwrite) begin
      case (i_paddr)
        OFS_CTRL: s_nxt.prdata = s_r.ctrl;
        OFS_IN_MAP: s_nxt.prdata = {8'h00, s_r.in_map};
        OFS_OUT_MAP: s_nxt.prdata = s_r.out_map;
        OFS_WIN_CFG: s_nxt.prdata = {8'h00, s_r.win_cfg};
        OFS_STATUS: begin
          s_nxt.prdata = '0;
          s_nxt.prdata[ST_FE_WARN_BIT] = s_r.warn[ST_FE_WARN_BIT];
          s_nxt.prdata[ST_RM_WARN_BIT] = s_r.warn[ST_RM_WARN_BIT];
          s_nxt.prdata[ST_SEQ_BIT] = s_r.seq_lvl;
          s_nxt.prdata[ST_JOG_BIT] = s_r.jog_act;
          s_nxt.prdata[ST_BLK_LSB +: 8] = blk_num;
          s_nxt.prdata[ST_PINS_LSB +: N_IN] = s_r.filt;
        end
        default: s_nxt.prdata = '0;
      endcase
    end
    // apb writes take effect at the access edge
    if (access_ph && i_pwrite) begin
      case (i_paddr)
        OFS_CTRL: s_nxt.ctrl = {31'h0000_0000, i_pwdata[CTRL_FORM_BIT]};
        OFS_IN_MAP: s_nxt.in_map = i_pwdata[23:0];
        OFS_OUT_MAP: s_nxt.out_map = i_pwdata;
        OFS_WIN_CFG: s_nxt.win_cfg = i_pwdata[23:0];
        default: s_nxt.ctrl = s_r.ctrl; // status and holes ignore writes
      endcase
    end
  end

  // state register, synchronous reset to the default functions
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_r <= '0;
      s_r.ctrl <= RST_CTRL;
      s_r.in_map <= RST_IN_MAP;
      s_r.out_map <= RST_OUT_MAP;
      s_r.win_cfg <= RST_WIN_CFG;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from flops
  always_comb begin
    o_prdata = s_r.prdata;
    o_pins = s_r.outs;
    o_cmd = s_r.cmd;
    o_warn = s_r.warn;
  end

  // checks
  // checks on flopped outputs look one edge ahead; o_pslverr is combinational, so its check is same-cycle
  // antecedents use the registered state so a mid-run write cannot confuse them
  // flag outputs lag their conditions by two edges, so flags are checked on s_r.win
  // command checks use the mapped levels, so they still hold after remapping
  tgt_out_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_r.out_map[3:0] == OF_TGT |=> o_pins[0] == $past(i_pos_in_window))
    else $error("target output does not follow window");
  fe_low_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_r.out_map[11:8] == OF_FE_N |=> o_pins[2] == !$past(i_follow_err_exceeded))
    else $error("following error output wrong level");
  next_gate_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_cmd.start_next |-> $past(i_pos_in_window) && $past(next_req))
    else $error("next task started outside window");
  next_ok_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_base_next_start && i_pos_in_window |=> o_cmd.start_next)
    else $error("base next request lost");
  warn_clr_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    fn_rise[FN_CLEAR] && !i_fe_warn_evt && !i_rm_warn_evt |=> o_warn == 2'b00)
    else $error("warnings not cleared");
  home_sel_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_base_home_sel |=> o_cmd.home_sw == $past(i_base_home))
    else $error("expansion home used while base home selected");
  jog_edge_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    fn_rise[FN_JOG] |=> o_cmd.jog_start && !o_cmd.jog_cancel ##1 !o_cmd.jog_start)
    else $error("jog start pulse wrong");
  start_sel_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    fn_rise[FN_START] && blk_num != 8'h00
    |=> o_cmd.start_task && o_cmd.task_num == $past(blk_num) && !o_cmd.start_home)
    else $error("addressed task not started");
  home_task_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    fn_rise[FN_START] && blk_num == 8'h00 |=> o_cmd.start_home && !o_cmd.start_task)
    else $error("homing not started for block zero");
  seq_first_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !s_r.ctrl[CTRL_FORM_BIT] && i_seq_task_start && i_seq_first |=> !s_r.seq_lvl)
    else $error("sequence output not low at first task");
  seq_tog_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !s_r.ctrl[CTRL_FORM_BIT] && i_seq_task_start && !i_seq_first
    |=> s_r.seq_lvl != $past(s_r.seq_lvl))
    else $error("sequence output did not toggle");
  filt_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $changed(s_r.filt[0]) |-> $past(s_r.cnt[0]) == CNT_W'(FILT_CYCLES - 1))
    else $error("filtered input changed before filter time");
  flag_one_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_r.win_cfg[7:4] == 4'h8 |=> s_r.win[1] == $past(i_pos_cond[0]))
    else $error("window flag one not tracking limit one");
  // resume gives a pulse on the edge after each rising edge
  resume_pulse_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    fn_rise[FN_RESUME] |=> o_cmd.resume)
    else $error("resume pulse missing");
  // falling jog edge cancels only a running jog
  jog_cancel_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    fn_fall[FN_JOG] && s_r.jog_act |=> o_cmd.jog_cancel && !s_r.jog_act)
    else $error("jog not cancelled on falling edge");
  // a warning event always sets its flag, even against a clear
  fe_warn_set_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_fe_warn_evt |=> o_warn[ST_FE_WARN_BIT])
    else $error("following error warning not set");
  rm_warn_set_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_rm_warn_evt |=> o_warn[ST_RM_WARN_BIT])
    else $error("response warning not set");
  // expansion home pin is used when the base unit does not own homing
  home_exp_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_base_home_sel |=> o_cmd.home_sw == $past(fn_now[FN_HOME]))
    else $error("expansion home level not passed on");
  // flag two follows limit two while its default selection stands
  flag_two_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_r.win_cfg[11:8] == 4'h9 |=> s_r.win[2] == $past(i_pos_cond[1]))
    else $error("window flag two not tracking limit two");
  // a flag without an enabled condition stays low
  flag_off_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !s_r.win_cfg[WIN_EN_BIT] |=> !s_r.win[0])
    else $error("unconfigured flag zero went high");
  // level form raises the sequence output at every task start
  seq_alt_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_r.ctrl[CTRL_FORM_BIT] && i_seq_task_start |=> s_r.seq_lvl)
    else $error("sequence output not raised in level form");
  // the sequence pin shows the sequence level one edge later
  seq_pin_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_r.out_map[7:4] == OF_SEQ |=> o_pins[1] == $past(s_r.seq_lvl))
    else $error("sequence pin does not follow level");
  // the task number is the select pins read as an unsigned number
  blk_num_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    fn_rise[FN_START] && blk_num != 8'h00 |=> o_cmd.task_num == $past(s_r.filt[7:0]))
    else $error("task number not taken from select pins");
  // an early next request is dropped, not stored
  next_early_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    next_req && !i_pos_in_window |=> !o_cmd.start_next)
    else $error("next task started before target reached");
  // unmapped addresses answer with an error
  bad_addr_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_psel && i_penable && !addr_ok |-> o_pslverr)
    else $error("unmapped address not refused");
  // an output map write lands at the access edge
  map_write_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_psel && i_penable && i_pwrite && i_paddr == OFS_OUT_MAP
    |=> s_r.out_map == $past(i_pwdata))
    else $error("output map write lost");
  start_cov: cover property (@(posedge i_sys_clk) disable iff (i_rst) o_cmd.start_task);
  // level form of the sequence output in use
  seq_alt_cov: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    s_r.ctrl[CTRL_FORM_BIT] && i_seq_task_start);
  jog_cov: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    o_cmd.jog_start ##[1:50] o_cmd.jog_cancel);
  next_cov: cover property (@(posedge i_sys_clk) disable iff (i_rst) o_cmd.start_next);
  seq_cov: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    i_seq_task_start && !i_seq_first);
endmodule

// ===== plc_model.sv
// behavioural model of the controller that drives the expansion inputs
module plc_model (
  input wire logic i_sys_clk,
  input wire logic [io_exp_pkg::N_IN-1:0] i_want,
  input wire logic i_chatter,
  output logic [io_exp_pkg::N_IN-1:0] o_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  import io_exp_pkg::*;

  // contacts are unknown until the first edge; the bench holds reset across it
  // contacts follow the wanted levels one edge later, block number lsb on pin 0
  always @(posedge i_sys_clk) begin
    o_pins <= i_want;
    // chatter flips the start contact every cycle, far shorter than the filter
    if (i_chatter) begin
      o_pins[13] <= ~o_pins[13];
    end
  end
endmodule

// ===== test_motion_task_io_expansion.sv
// self-checking bench for the motion task i/o expansion
module test_motion_task_io_expansion;
  timeunit 1ns;
  timeprecision 1ps;
  import io_exp_pkg::*;

  localparam int FILT = 4; // short filter keeps the run brief
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [N_IN-1:0] want = '0; // levels the controller wants on the pins
  logic chatter = 1'b0;
  logic [N_IN-1:0] pins;
  logic [N_OUT-1:0] opins;
  logic in_win = 1'b0;
  logic fe_exc = 1'b0;
  logic [7:0] pos_cond = 8'h00;
  logic seq_go = 1'b0;
  logic seq_first = 1'b0;
  logic fe_evt = 1'b0;
  logic rm_evt = 1'b0;
  logic home_sel = 1'b0;
  logic base_home = 1'b0;
  logic base_next = 1'b0;
  cmd_t cmd;
  logic [1:0] warn;
  int mismatches = 0;
  int checked = 0;
  int ev[6] = '{default: 0}; // start, home, next, resume, jog start, jog cancel
  int base[6];
  logic [7:0] num_seen = 8'h00; // block number seen with the last start

  initial begin
    forever #10 clk = ~clk;
  end

  plc_model i_plc_model (.i_sys_clk(clk), .i_want(want), .i_chatter(chatter), .o_pins(pins));

  motion_task_io_expansion #(.FILT_CYCLES(FILT)) i_motion_task_io_expansion (
    .i_sys_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_pins(pins), .o_pins(opins), .i_pos_in_window(in_win),
    .i_follow_err_exceeded(fe_exc), .i_pos_cond(pos_cond), .i_seq_task_start(seq_go),
    .i_seq_first(seq_first), .i_fe_warn_evt(fe_evt), .i_rm_warn_evt(rm_evt),
    .i_base_home_sel(home_sel), .i_base_home(base_home), .i_base_next_start(base_next),
    .o_cmd(cmd), .o_warn(warn));

  // count command pulses; one-cycle pulses are seen at the edge after they appear
  always @(posedge clk) begin
    if (!rst) begin
      ev[0] += (cmd.start_task === 1'b1);
      ev[1] += (cmd.start_home === 1'b1);
      ev[2] += (cmd.start_next === 1'b1);
      ev[3] += (cmd.resume === 1'b1);
      ev[4] += (cmd.jog_start === 1'b1);
      ev[5] += (cmd.jog_cancel === 1'b1);
      if (cmd.start_task === 1'b1) begin
        num_seen = cmd.task_num;
      end
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (mismatches == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      mismatches++;
      results();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, experr});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  // long enough for sync, filter and command register
  task automatic settle();
    repeat (FILT + 8) @(posedge clk);
  endtask

  task automatic snap();
    base = ev;
  endtask

  // press and release one command contact
  task automatic press(input int idx);
    @(posedge clk);
    want[idx] <= 1'b1;
    settle();
    want[idx] <= 1'b0;
    settle();
  endtask

  task automatic seqpulse(input logic first);
    @(posedge clk);
    seq_go <= 1'b1;
    seq_first <= first;
    @(posedge clk);
    seq_go <= 1'b0;
    seq_first <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_CTRL, RST_CTRL, 1'b0);
    rd(OFS_IN_MAP, {8'h00, RST_IN_MAP}, 1'b0);
    rd(OFS_OUT_MAP, RST_OUT_MAP, 1'b0);
    rd(OFS_WIN_CFG, {8'h00, RST_WIN_CFG}, 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    rd(OFS_STATUS, 32'h0, 1'b0);
    // status outputs at their defaults
    in_win <= 1'b1;
    fe_exc <= 1'b1;
    pos_cond <= 8'hff;
    repeat (4) @(posedge clk);
    chk(opins, 8'h19);
    in_win <= 1'b0;
    fe_exc <= 1'b0;
    pos_cond <= 8'h00;
    repeat (4) @(posedge clk);
    chk(opins, 8'h04);
    // sequence step toggling, first task forces low
    seqpulse(1'b0);
    chk(opins[1], 1'b1);
    seqpulse(1'b1);
    chk(opins[1], 1'b0);
    seqpulse(1'b0);
    chk(opins[1], 1'b1);
    // addressed start with an awkward block number
    want[7:0] <= 8'hae;
    settle();
    snap();
    press(13);
    chk(ev[0] - base[0], 1);
    chk(num_seen, 8'hae);
    rd(OFS_STATUS, 32'h00ae_ae04, 1'b0);
    want[7:0] <= 8'h00;
    settle();
    snap();
    press(13);
    chk(ev[1] - base[1], 1);
    chk(ev[0] - base[0], 0);
    // next task refused until in position
    snap();
    press(10);
    chk(ev[2] - base[2], 0);
    in_win <= 1'b1;
    snap();
    press(10);
    chk(ev[2] - base[2], 1);
    snap();
    base_next <= 1'b1;
    @(posedge clk);
    base_next <= 1'b0;
    settle();
    chk(ev[2] - base[2], 1);
    // jog rise starts, fall cancels
    snap();
    want[11] <= 1'b1;
    settle();
    chk(ev[4] - base[4], 1);
    chk(ev[5] - base[5], 0);
    want[11] <= 1'b0;
    settle();
    chk(ev[5] - base[5], 1);
    snap();
    press(12);
    chk(ev[3] - base[3], 1);
    // warnings set by the core, cleared by the contact
    fe_evt <= 1'b1;
    rm_evt <= 1'b1;
    @(posedge clk);
    fe_evt <= 1'b0;
    rm_evt <= 1'b0;
    repeat (2) @(posedge clk);
    chk(warn, 2'b11);
    press(9);
    chk(warn, 2'b00);
    // home switch source
    want[8] <= 1'b1;
    settle();
    chk(cmd.home_sw, 1'b1);
    home_sel <= 1'b1;
    repeat (4) @(posedge clk);
    chk(cmd.home_sw, 1'b0);
    // bouncing start contact gives nothing
    snap();
    chatter <= 1'b1;
    repeat (30) @(posedge clk);
    chatter <= 1'b0;
    settle();
    chk(ev[0] - base[0] + ev[1] - base[1], 0);
    // alternate sequence form
    wr(OFS_CTRL, 32'h1);
    rd(OFS_CTRL, 32'h1, 1'b0);
    in_win <= 1'b0;
    seqpulse(1'b0);
    chk(opins[1], 1'b1);
    in_win <= 1'b1;
    repeat (3) @(posedge clk);
    chk(opins[1], 1'b0);
    // output pin 0 remapped to the following error flag
    wr(OFS_OUT_MAP, 32'h9876_5323);
    repeat (3) @(posedge clk);
    chk(opins[0], 1'b1);
    fe_exc <= 1'b1;
    repeat (3) @(posedge clk);
    chk(opins[0], 1'b0);
    results();
  end
endmodule
